// ---- logic/assf_top.sv ----
/*
 Asynchronous serial unit with status flags, 8N1 transmitter and receiver,
 Wishbone classic register slave and a masked level interrupt.
 Assumes a single clock; the rx pin is asynchronous and synchronised here.
*/
// The implementer's own choices: the Wishbone register port and the register addresses.
// Functional notes
// - Writing one to status flags does nothing.
// - Tx empty is bit 7, resets set.
// - Tx empty sets on holding-to-shift move.
// - Tx empty clears on zero after one-read.
// - Tx empty clears on transmit data write.
// - Rx full bit 6 sets on good receive.
// - Rx full clears on zero after one-read.
// - Reading received data clears rx full.
// - Overrun bit 5 sets on receive overrun.
// - Overrun clears only by zero after one-read.
// - Framing bit 4 sets on bad stop.
// - Framing clears only by zero after one-read.
// - Zero select and divisor give clock/32 rate.
`timescale 1ns/10ps
module assf_top #(
	parameter int DIV_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic txd_o,
	input wire logic rxd_i,
	output logic irq_o
);
	// ----------------------------------------------------------------
	// Types and registers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ASSF_IDLE = 2'b00,
		ASSF_START = 2'b01,
		ASSF_DATA = 2'b10,
		ASSF_STOP = 2'b11
	} assf_state_t;

	logic [7:0] status_reg;
	logic [7:0] seen_reg;
	logic [7:0] control_reg;
	logic [9:0] bitrate_reg;
	logic [7:0] tx_holding_register;
	logic [9:0] tx_shift_register;
	logic [7:0] rx_holding_register;
	logic [7:0] rx_shift_register;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	assf_state_t tx_state_reg;
	assf_state_t rx_state_reg;
	logic [3:0] tx_os_reg;
	logic [3:0] tx_bit_reg;
	logic [3:0] rx_os_reg;
	logic [3:0] rx_bit_reg;
	logic rx_meta_reg;
	logic rx_sync_reg;
	logic tick;
	logic wr_stb;
	logic rd_stb;
	logic wr_status;
	logic wr_txdata;
	logic rd_status;
	logic rd_rxdata;
	logic tx_load;
	logic rx_done;
	logic rx_good;
	logic rx_bad;
	logic rx_overrun;
	logic [31:0] rd_mux;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
	assign rd_stb = cyc_i && stb_i && !we_i && !ack_o;
	assign wr_status = wr_stb && (adr_i == assf_pkg::ASSF_OFF_STATUS);
	assign wr_txdata = wr_stb && (adr_i == assf_pkg::ASSF_OFF_TXDATA);
	assign rd_status = rd_stb && (adr_i == assf_pkg::ASSF_OFF_STATUS);
	assign rd_rxdata = rd_stb && (adr_i == assf_pkg::ASSF_OFF_RXDATA);

	// ----------------------------------------------------------------
	// Read data and acknowledge
	// ----------------------------------------------------------------
	always_comb begin
		case (adr_i)
			assf_pkg::ASSF_OFF_STATUS: rd_mux = {24'h000000, status_reg};
			assf_pkg::ASSF_OFF_CONTROL: rd_mux = {24'h000000, control_reg};
			assf_pkg::ASSF_OFF_TXDATA: rd_mux = {24'h000000, tx_holding_register};
			assf_pkg::ASSF_OFF_RXDATA: rd_mux = {24'h000000, rx_holding_register};
			assf_pkg::ASSF_OFF_BITRATE: rd_mux = {22'h0, bitrate_reg};
			assf_pkg::ASSF_OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
			assf_pkg::ASSF_OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else if (ce_i) begin
			ack_o <= cyc_i && stb_i && !ack_o;
			if (rd_stb) begin
				dat_o <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_reg <= assf_pkg::ASSF_CONTROL_RST;
			bitrate_reg <= assf_pkg::ASSF_BITRATE_RST;
			irq_mask_reg <= 3'h0;
		end else if (ce_i && wr_stb) begin
			if (adr_i == assf_pkg::ASSF_OFF_CONTROL) begin
				control_reg <= dat_i[7:0];
			end
			if (adr_i == assf_pkg::ASSF_OFF_BITRATE) begin
				bitrate_reg <= dat_i[9:0];
			end
			if (adr_i == assf_pkg::ASSF_OFF_IRQ_MASK) begin
				irq_mask_reg <= dat_i[2:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bit-rate generator
	// ----------------------------------------------------------------
	assf_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sel_i(bitrate_reg[9:8]),
		.div_i(bitrate_reg[DIV_W-1:0]),
		.tick_o(tick)
	);

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	assign tx_load = (tx_state_reg == ASSF_IDLE) && !status_reg[assf_pkg::ASSF_BIT_TXE]
		&& control_reg[assf_pkg::ASSF_CTL_TXEN] && tick;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_holding_register <= 8'h00;
		end else if (ce_i && wr_txdata) begin
			tx_holding_register <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_reg <= ASSF_IDLE;
			tx_shift_register <= 10'h3ff;
			tx_os_reg <= 4'h0;
			tx_bit_reg <= 4'h0;
			txd_o <= 1'b1;
		end else if (ce_i) begin
			case (tx_state_reg)
				ASSF_IDLE: begin
					txd_o <= 1'b1;
					if (tx_load) begin
						tx_shift_register <= {1'b1, tx_holding_register, 1'b0};
						tx_state_reg <= ASSF_DATA;
						tx_os_reg <= 4'h0;
						tx_bit_reg <= 4'h0;
					end
				end
				ASSF_DATA: begin
					if (tick) begin
						txd_o <= tx_shift_register[0];
						tx_os_reg <= tx_os_reg + 4'h1;
						if (tx_os_reg == assf_pkg::ASSF_SAMPLE_LAST) begin
							tx_shift_register <= {1'b1, tx_shift_register[9:1]};
							tx_bit_reg <= tx_bit_reg + 4'h1;
							if (tx_bit_reg == assf_pkg::ASSF_DATA_BITS + 4'h1) begin
								tx_state_reg <= ASSF_IDLE;
							end
						end
					end
				end
				default: begin
					tx_state_reg <= ASSF_IDLE;
					txd_o <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else if (ce_i) begin
			rx_meta_reg <= rxd_i;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	assign rx_done = (rx_state_reg == ASSF_STOP) && tick && (rx_os_reg == assf_pkg::ASSF_SAMPLE_LAST);
	assign rx_overrun = rx_done && rx_sync_reg && status_reg[assf_pkg::ASSF_BIT_RXF];
	assign rx_good = rx_done && rx_sync_reg && !status_reg[assf_pkg::ASSF_BIT_RXF];
	assign rx_bad = rx_done && !rx_sync_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_reg <= ASSF_IDLE;
			rx_os_reg <= 4'h0;
			rx_bit_reg <= 4'h0;
			rx_shift_register <= 8'h00;
			rx_holding_register <= 8'h00;
		end else if (ce_i && tick) begin
			rx_os_reg <= rx_os_reg + 4'h1;
			case (rx_state_reg)
				ASSF_IDLE: begin
					rx_os_reg <= 4'h0;
					if (!rx_sync_reg && control_reg[assf_pkg::ASSF_CTL_RXEN]) begin
						rx_state_reg <= ASSF_START;
					end
				end
				ASSF_START: begin
					if (rx_os_reg == assf_pkg::ASSF_SAMPLE_MID) begin
						rx_os_reg <= 4'h0;
						rx_bit_reg <= 4'h0;
						rx_state_reg <= rx_sync_reg ? ASSF_IDLE : ASSF_DATA;
					end
				end
				ASSF_DATA: begin
					if (rx_os_reg == assf_pkg::ASSF_SAMPLE_LAST) begin
						rx_shift_register <= {rx_sync_reg, rx_shift_register[7:1]};
						rx_bit_reg <= rx_bit_reg + 4'h1;
						if (rx_bit_reg == assf_pkg::ASSF_DATA_BITS - 4'h1) begin
							rx_state_reg <= ASSF_STOP;
							rx_os_reg <= 4'h0;
						end
					end
				end
				ASSF_STOP: begin
					if (rx_os_reg == assf_pkg::ASSF_SAMPLE_LAST) begin
						rx_state_reg <= ASSF_IDLE;
						if (rx_good) begin
							rx_holding_register <= rx_shift_register;
						end
					end
				end
				default: rx_state_reg <= ASSF_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seen_reg <= 8'h00;
		end else if (ce_i) begin
			if (rd_status) begin
				seen_reg <= status_reg;
			end else if (wr_status) begin
				seen_reg <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Flag set and clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= assf_pkg::ASSF_STATUS_RST;
		end else if (ce_i) begin
			if (!control_reg[assf_pkg::ASSF_CTL_TXEN] || tx_load) begin
				status_reg[assf_pkg::ASSF_BIT_TXE] <= 1'b1;
			end else if (wr_txdata) begin
				status_reg[assf_pkg::ASSF_BIT_TXE] <= 1'b0;
			end else if (wr_status && seen_reg[assf_pkg::ASSF_BIT_TXE]
				&& !dat_i[assf_pkg::ASSF_BIT_TXE]) begin
				status_reg[assf_pkg::ASSF_BIT_TXE] <= 1'b0;
			end
			if (rx_good) begin
				status_reg[assf_pkg::ASSF_BIT_RXF] <= 1'b1;
			end else if (rd_rxdata) begin
				status_reg[assf_pkg::ASSF_BIT_RXF] <= 1'b0;
			end else if (wr_status && seen_reg[assf_pkg::ASSF_BIT_RXF]
				&& !dat_i[assf_pkg::ASSF_BIT_RXF]) begin
				status_reg[assf_pkg::ASSF_BIT_RXF] <= 1'b0;
			end
			if (rx_overrun) begin
				status_reg[assf_pkg::ASSF_BIT_OVR] <= 1'b1;
			end else if (wr_status && seen_reg[assf_pkg::ASSF_BIT_OVR]
				&& !dat_i[assf_pkg::ASSF_BIT_OVR]) begin
				status_reg[assf_pkg::ASSF_BIT_OVR] <= 1'b0;
			end
			if (rx_bad) begin
				status_reg[assf_pkg::ASSF_BIT_FRM] <= 1'b1;
			end else if (wr_status && seen_reg[assf_pkg::ASSF_BIT_FRM]
				&& !dat_i[assf_pkg::ASSF_BIT_FRM]) begin
				status_reg[assf_pkg::ASSF_BIT_FRM] <= 1'b0;
			end
			status_reg[assf_pkg::ASSF_BIT_PAR] <= 1'b0;
			status_reg[2:0] <= 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= 3'h0;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(irq_stat_reg & irq_mask_reg);
			irq_stat_reg[assf_pkg::ASSF_IRQ_TXE] <= tx_load || (irq_stat_reg[assf_pkg::ASSF_IRQ_TXE]
				&& !(wr_stb && adr_i == assf_pkg::ASSF_OFF_IRQ_STAT && dat_i[assf_pkg::ASSF_IRQ_TXE]));
			irq_stat_reg[assf_pkg::ASSF_IRQ_RXF] <= rx_good || (irq_stat_reg[assf_pkg::ASSF_IRQ_RXF]
				&& !(wr_stb && adr_i == assf_pkg::ASSF_OFF_IRQ_STAT && dat_i[assf_pkg::ASSF_IRQ_RXF]));
			irq_stat_reg[assf_pkg::ASSF_IRQ_ERR] <= rx_bad || rx_overrun
				|| (irq_stat_reg[assf_pkg::ASSF_IRQ_ERR]
				&& !(wr_stb && adr_i == assf_pkg::ASSF_OFF_IRQ_STAT && dat_i[assf_pkg::ASSF_IRQ_ERR]));
		end
	end
endmodule

// ---- logic/assf_pkg.sv ----
/*
 Package for the serial status flag block: register offsets, bit positions,
 reset values and bit-rate constants.
 Assumes a 32-bit classic Wishbone slave port, byte addressed.
*/
package assf_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ASSF_OFF_STATUS = 8'h00;
	localparam logic [7:0] ASSF_OFF_CONTROL = 8'h04;
	localparam logic [7:0] ASSF_OFF_TXDATA = 8'h08;
	localparam logic [7:0] ASSF_OFF_RXDATA = 8'h0c;
	localparam logic [7:0] ASSF_OFF_BITRATE = 8'h10;
	localparam logic [7:0] ASSF_OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] ASSF_OFF_IRQ_MASK = 8'h18;
	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int ASSF_BIT_TXE = 7;
	localparam int ASSF_BIT_RXF = 6;
	localparam int ASSF_BIT_OVR = 5;
	localparam int ASSF_BIT_FRM = 4;
	localparam int ASSF_BIT_PAR = 3;
	// ----------------------------------------------------------------
	// Control bit positions
	// ----------------------------------------------------------------
	localparam int ASSF_CTL_TXEN = 5;
	localparam int ASSF_CTL_RXEN = 4;
	// ----------------------------------------------------------------
	// Interrupt bit positions
	// ----------------------------------------------------------------
	localparam int ASSF_IRQ_TXE = 0;
	localparam int ASSF_IRQ_RXF = 1;
	localparam int ASSF_IRQ_ERR = 2;
	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] ASSF_STATUS_RST = 8'h80;
	localparam logic [7:0] ASSF_CONTROL_RST = 8'h00;
	localparam logic [9:0] ASSF_BITRATE_RST = 10'h000;
	localparam int ASSF_OVERSAMPLE = 16;
	localparam int ASSF_BASE_DIV = 2;
	localparam logic [3:0] ASSF_SAMPLE_MID = 4'h7;
	localparam logic [3:0] ASSF_SAMPLE_LAST = 4'hf;
	localparam logic [3:0] ASSF_DATA_BITS = 4'h8;
endpackage

// ---- logic/assf_baud_gen.sv ----
/*
 Bit-rate tick generator: prescaler of 2, 8, 32 or 128 then divisor plus one.
 Assumes the caller's clock and a clock enable shared with the main block.
*/
`timescale 1ns/10ps
module assf_baud_gen #(
	parameter int DIV_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [1:0] sel_i,
	input wire logic [DIV_W-1:0] div_i,
	output logic tick_o
);
	// ----------------------------------------------------------------
	// Prescaler and divisor
	// ----------------------------------------------------------------
	logic [6:0] pre_reg;
	logic [DIV_W-1:0] cnt_reg;
	logic pre_hit;
	logic [6:0] pre_top;

	always_comb begin
		case (sel_i)
			2'h0: pre_top = 7'h01;
			2'h1: pre_top = 7'h07;
			2'h2: pre_top = 7'h1f;
			default: pre_top = 7'h7f;
		endcase
		pre_hit = (pre_reg >= pre_top);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_reg <= 7'h00;
		end else if (ce_i) begin
			pre_reg <= pre_hit ? 7'h00 : pre_reg + 7'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			tick_o <= 1'b0;
			if (pre_hit) begin
				if (cnt_reg >= div_i) begin
					cnt_reg <= '0;
					tick_o <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// ---- bench/assf_top_sva.sv ----
/*
 Checker for the serial status flag block, bound to its top module.
 Assumes one clock with a synchronous active-high reset.
*/
`timescale 1ns/10ps
module assf_top_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic txd_o,
	input wire logic rxd_i,
	input wire logic irq_o
);
	// ------------------------------
	// Bus shadows and line idle count
	// ------------------------------
	logic take;
	logic we_q;
	logic rd_stat_q;
	logic unmapped_q;
	logic txen_q;
	logic br_zero_q;
	logic [8:0] idle_cnt;
	assign take = cyc_i && stb_i && !ack_o && ce_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			we_q <= 1'b0;
			rd_stat_q <= 1'b0;
			unmapped_q <= 1'b0;
			txen_q <= 1'b0;
			br_zero_q <= 1'b1;
		end else if (take) begin
			we_q <= we_i;
			rd_stat_q <= !we_i && adr_i == assf_pkg::ASSF_OFF_STATUS;
			unmapped_q <= adr_i > assf_pkg::ASSF_OFF_IRQ_MASK || adr_i[1:0] != 2'h0;
			if (we_i && sel_i[0] && adr_i == assf_pkg::ASSF_OFF_CONTROL) begin
				txen_q <= dat_i[assf_pkg::ASSF_CTL_TXEN];
			end
			if (we_i && sel_i[0] && adr_i == assf_pkg::ASSF_OFF_BITRATE) begin
				br_zero_q <= dat_i[9:0] == 10'h000;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || !txd_o) begin
			idle_cnt <= 9'h000;
		end else if (idle_cnt != 9'h1ff) begin
			idle_cnt <= idle_cnt + 9'h001;
		end
	end
	// ------------------------------
	// Assertions
	// ------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && txd_o && !irq_o && dat_o == 32'h0)
		else $error("outputs not quiet after reset");
	ack_answer_a: assert property (take |=> ack_o)
		else $error("request not answered in one cycle");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	txe_forced_a: assert property (ack_o && rd_stat_q && !txen_q |-> dat_o[7])
		else $error("tx empty clear while tx disabled");
	unmapped_zero_a: assert property (ack_o && !we_q && unmapped_q |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	upper_zero_a: assert property (ack_o && !we_q |-> dat_o[31:10] == 22'h0)
		else $error("upper read bits not zero");
	start_bit_a: assert property ($fell(txd_o) && idle_cnt >= 9'hf0 && br_zero_q
		|-> ##24 (!txd_o) [*8])
		else $error("start bit not thirty-two clocks");
	cover property (ack_o && rd_stat_q);
	cover property ($fell(txd_o) && idle_cnt >= 9'hf0);
	cover property ($rose(irq_o));
endmodule

// ---- bench/assf_remote_peer.sv ----
/*
 Remote serial peer: 8N1 transmitter and receiver at a fixed bit time.
 Assumes the design's clock; the line idles high.
*/
`timescale 1ns/10ps
module assf_remote_peer #(
	parameter int BIT_CLKS = 32
) (
	input wire logic clk_i,
	input wire logic txd_i,
	output logic rxd_o
);
	// ------------------------------
	// Frame sender and receiver
	// ------------------------------
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	initial rxd_o = 1'b1;
	task automatic send(input logic [7:0] b, input logic stop_ok);
		logic [9:0] fr;
		fr = {stop_ok, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= fr[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask
	always begin
		@(negedge txd_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk_i);
			sh[i] = txd_i;
		end
		repeat (BIT_CLKS) @(posedge clk_i);
		if (txd_i === 1'b1) rx_q.push_back(sh);
	end
endmodule

// ---- bench/tb.sv ----
/*
 Testbench for the serial status flag block: register sequences over
 Wishbone and serial traffic against the remote peer model.
 Assumes the design package and design files are compiled first.
*/
`timescale 1ns/10ps
module tb;
	// ------------------------------
	// Signals, tasks and tests
	// ------------------------------
	localparam logic [7:0] ST = assf_pkg::ASSF_OFF_STATUS;
	localparam logic [7:0] CT = assf_pkg::ASSF_OFF_CONTROL;
	localparam logic [7:0] TX = assf_pkg::ASSF_OFF_TXDATA;
	localparam logic [7:0] RX = assf_pkg::ASSF_OFF_RXDATA;
	localparam logic [7:0] IS = assf_pkg::ASSF_OFF_IRQ_STAT;
	localparam logic [7:0] IM = assf_pkg::ASSF_OFF_IRQ_MASK;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic txd_o;
	logic rxd_i;
	logic irq_o;
	int error_cnt = 0;
	int num_checks = 0;
	always #50 clk_i = ~clk_i;
	assf_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .txd_o(txd_o), .rxd_i(rxd_i), .irq_o(irq_o));
	assf_remote_peer peer (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		we_i <= w;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h0, 32'h1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic rx(input logic [7:0] b, input logic ok);
		peer.send(b, ok);
		repeat (4) @(posedge clk_i);
	endtask
	task automatic irq_is(input logic exp);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq_o}, {31'h0, exp});
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(ST, 32'h80);
		rd(CT, 32'h0);
		rd(8'h1c, 32'h0);
		wr(ST, 32'hff);
		rd(ST, 32'h80);
		wr(ST, 32'h0);
		rd(ST, 32'h80);
		wr(assf_pkg::ASSF_OFF_BITRATE, 32'hffff_fedc);
		rd(assf_pkg::ASSF_OFF_BITRATE, 32'h2dc);
		wr(assf_pkg::ASSF_OFF_BITRATE, 32'h0);
		wr(CT, 32'h30);
		rd(ST, 32'h80);
		repeat (250) @(posedge clk_i);
		wr(TX, 32'h5a);
		repeat (4) @(posedge clk_i);
		rd(ST, 32'h80);
		wr(TX, 32'hc3);
		rd(ST, 32'h0);
		for (int i = 0; i < 2000 && peer.rx_q.size() < 1; i++) @(posedge clk_i);
		repeat (40) @(posedge clk_i);
		rd(ST, 32'h80);
		wr(ST, 32'h0);
		rd(ST, 32'h0);
		for (int i = 0; i < 2000 && peer.rx_q.size() < 3; i++) @(posedge clk_i);
		rd(ST, 32'h80);
		chk(peer.rx_q.size(), 32'h3);
		chk({24'h0, peer.rx_q[0]}, 32'h5a);
		chk({24'h0, peer.rx_q[1]}, 32'hc3);
		chk({24'h0, peer.rx_q[2]}, 32'hc3);
		wr(CT, 32'h10);
		wr(IS, 32'h7);
		wr(IM, 32'h6);
		rx(8'h3c, 1'b1);
		rd(ST, 32'hc0);
		rd(RX, 32'h3c);
		rd(ST, 32'h80);
		rx(8'h11, 1'b1);
		rd(ST, 32'hc0);
		wr(ST, 32'h0);
		rd(ST, 32'h80);
		rd(ST, 32'h80);
		rx(8'h22, 1'b1);
		wr(ST, 32'h0);
		rd(ST, 32'hc0);
		rx(8'h33, 1'b1);
		rd(ST, 32'he0);
		rd(RX, 32'h22);
		rd(ST, 32'ha0);
		wr(ST, 32'hff);
		rd(ST, 32'ha0);
		wr(ST, 32'h0);
		rd(ST, 32'h80);
		rx(8'h44, 1'b0);
		rd(ST, 32'h90);
		rd(RX, 32'h22);
		rd(ST, 32'h90);
		wr(ST, 32'h0);
		rd(ST, 32'h80);
		irq_is(1'b1);
		rd(IS, 32'h6);
		wr(IM, 32'h0);
		irq_is(1'b0);
		wr(IM, 32'h6);
		irq_is(1'b1);
		wr(IS, 32'h6);
		irq_is(1'b0);
		rd(IS, 32'h0);
		conclude;
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		error_cnt++;
		conclude;
	end
endmodule
bind assf_top assf_top_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .txd_o(txd_o), .rxd_i(rxd_i), .irq_o(irq_o));
